// file: hw/i2c_target_tx.sv
// target-transmit state handling with no-info and bus-error status
//
// How it works
// R1: own read address acked reports A8
// R2: ack flag low on release: final byte
// R3: ack flag high on release: more bytes
// R4: arbitration lost then read-addressed reports B0
// R5: acked data byte reports B8, waits software
// R6: software loads byte, stop low, clears flag
// R7: unacked byte reports C0, leaves addressed mode
// R8: ack flag high: own address recognised again
// R9: start flag set: START once bus free
// R10: flag clear reads status F8
// R11: software takes no action on F8
// R12: misplaced START/STOP gives status 00
// R13: undefined internal state gives status 00
// R14: recovery: software sets stop, clears flag
// R15: recovery enters unaddressed, hardware clears stop
// R16: recovery releases lines, no STOP sent
// R17: recovery touches only internal state
// R18: bus errors only while taking part
// R19: final byte acked reports C8, then unaddressed
// R20: SCL held low while status pending; for bus error status 00 the code releases SCL at once
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module i2c_target_tx
    import i2c_tt_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // bus lines, open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    // controller engine
    input wire logic ctrl_arb_lost_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    line_events_if ev ();

    line_watch u_watch (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev.src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, code_q, code_d, tx_data_q, tx_data_d, own_q, own_d;
    logic [7:0] timer_q, timer_d, rdata_q, rdata_d;
    logic int_q, int_d, start_q, start_d, stop_q, stop_d, ack_q, ack_d;
    logic last_q, last_d, lost_q, lost_d, gc_q, gc_d, ackbit_q, ackbit_d;
    logic busy_q, busy_d, pend_q, pend_d, sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
    logic involved, bus_err_evt, ctrl_wr;
    logic [7:0] rx_byte;

    assign ctrl_wr = reg_wr_i && (reg_addr_i == OFS_CTRL);
    assign rx_byte = {sh_q[6:0], ev.sda_lvl};

    // bus errors count only while addressed or acting as controller
    assign involved = (state_q == S_ADDR_ACK) || (state_q == S_TX_BIT) ||
        (state_q == S_TX_ACK) ||
        ((state_q == S_WAIT) && (is_tx_code(code_q) || code_q == ST_START_SENT)); // [R18]
    assign bus_err_evt = (ev.start_det || ev.stop_det) && involved; // [R12]

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        code_d = code_q;
        tx_data_d = tx_data_q;
        own_d = own_q;
        timer_d = timer_q;
        int_d = int_q;
        start_d = start_q;
        stop_d = stop_q;
        ack_d = ack_q;
        last_d = last_q;
        lost_d = lost_q;
        gc_d = gc_q;
        ackbit_d = ackbit_q;
        busy_d = busy_q;
        pend_d = pend_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = scl_oe_q;
        rdata_d = 8'h00;

        // software side; writing one to the flag bit does nothing
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_CTRL: begin
                    start_d = reg_wdata_i[CTRL_START];
                    stop_d = reg_wdata_i[CTRL_STOP];
                    ack_d = reg_wdata_i[CTRL_ACK];
                    if (!reg_wdata_i[CTRL_INT]) begin
                        int_d = 1'b0;
                    end
                end
                OFS_DATA: tx_data_d = reg_wdata_i;
                OFS_ADR: own_d = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CTRL: rdata_d = {2'b00, start_q, stop_q, int_q, ack_q, 2'b00};
                OFS_STAT: rdata_d = int_q ? code_q : ST_NO_INFO; // [R10]
                OFS_DATA: rdata_d = tx_data_q;
                OFS_ADR: rdata_d = own_q;
                default: rdata_d = 8'h00;
            endcase
        end

        if (ev.start_det) begin
            busy_d = 1'b1;
        end
        if (ev.stop_det) begin
            busy_d = 1'b0;
        end

        // hardware writes come last so a set beats a same-cycle clear
        if (bus_err_evt) begin
            state_d = S_ERR; // [R12]
            code_d = ST_BUS_ERR;
            int_d = 1'b1;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (pend_q && !busy_q) begin
                        state_d = S_START; // [R9]
                        pend_d = 1'b0;
                        sda_oe_d = 1'b1;
                        timer_d = START_HOLD_CYC;
                    end else if (ev.start_det) begin
                        state_d = S_ADDR;
                        cnt_d = 4'h0;
                        lost_d = 1'b0;
                    end
                end
                S_ADDR: begin
                    if (ctrl_arb_lost_i) begin
                        lost_d = 1'b1;
                    end
                    if (ev.start_det) begin
                        cnt_d = 4'h0;
                    end else if (ev.stop_det) begin
                        state_d = S_IDLE;
                    end else if (ev.scl_rise) begin
                        sh_d = rx_byte;
                        cnt_d = 4'(cnt_q + 4'h1);
                        if (cnt_q == LAST_BIT) begin
                            // ack flag low: neither own nor broadcast address answered
                            gc_d = (rx_byte == 8'h00) && own_q[0];
                            if (ack_q && ((rx_byte[7:1] == own_q[7:1] && rx_byte[0]) ||
                                (rx_byte == 8'h00 && own_q[0]))) begin
                                state_d = S_ADDR_ACK; // [R8]
                            end else begin
                                state_d = S_IDLE;
                            end
                        end
                    end
                end
                S_ADDR_ACK: begin
                    if (ev.scl_fall && cnt_q == ACK_DRIVE) begin
                        sda_oe_d = 1'b1;
                        cnt_d = ACK_DONE;
                    end else if (ev.scl_fall) begin
                        sda_oe_d = 1'b0;
                        if (gc_q) begin
                            // receive side lives elsewhere; only the ack is given here
                            state_d = S_IDLE;
                        end else begin
                            state_d = S_WAIT;
                            int_d = 1'b1;
                            scl_oe_d = 1'b1; // [R20]
                            code_d = lost_q ? ST_ARB_LOST_RD : ST_ADDR_RD_ACK; // [R1] [R4]
                        end
                    end
                end
                S_WAIT: begin
                    if (!int_q) begin
                        scl_oe_d = 1'b0;
                        if (is_tx_code(code_q)) begin
                            state_d = S_TX_BIT;
                            last_d = !ack_q; // [R2] [R3]
                            sh_d = tx_data_q;
                            sda_oe_d = !tx_data_q[7];
                            cnt_d = 4'h0;
                        end else begin
                            state_d = S_IDLE; // [R7] [R19]
                            sda_oe_d = 1'b0;
                            lost_d = 1'b0;
                            if (start_q) begin
                                pend_d = 1'b1; // [R9]
                            end
                        end
                    end
                end
                S_TX_BIT: begin
                    if (ev.scl_fall) begin
                        cnt_d = 4'(cnt_q + 4'h1);
                        if (cnt_q == LAST_BIT) begin
                            sda_oe_d = 1'b0;
                            state_d = S_TX_ACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            sda_oe_d = !sh_q[6];
                        end
                    end
                end
                S_TX_ACK: begin
                    if (ev.scl_rise) begin
                        ackbit_d = ev.sda_lvl;
                    end
                    if (ev.scl_fall) begin
                        state_d = S_WAIT;
                        int_d = 1'b1;
                        scl_oe_d = 1'b1; // [R20]
                        if (ackbit_q) begin
                            code_d = ST_DATA_NACK; // [R7]
                        end else if (last_q) begin
                            code_d = ST_LAST_ACK; // [R19]
                        end else begin
                            code_d = ST_DATA_ACK; // [R5]
                        end
                    end
                end
                S_ERR: begin
                    // lines already released; nothing more goes onto the bus
                    if (!int_q && stop_q) begin
                        state_d = S_IDLE; // [R15] [R16] [R17]
                        if (!ctrl_wr) begin
                            stop_d = 1'b0;
                        end
                    end
                end
                S_START: begin
                    if (timer_q == 8'h01) begin
                        state_d = S_WAIT;
                        scl_oe_d = 1'b1;
                        int_d = 1'b1;
                        code_d = ST_START_SENT;
                    end else begin
                        timer_d = 8'(timer_q - 8'h01);
                    end
                end
                default: begin
                    state_d = S_ERR; // [R13]
                    code_d = ST_BUS_ERR;
                    int_d = 1'b1;
                    sda_oe_d = 1'b0;
                    scl_oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            code_q <= ST_NO_INFO;
            tx_data_q <= RST_TX_DATA;
            own_q <= RST_OWN_ADDR;
            timer_q <= 8'h00;
            rdata_q <= 8'h00;
            int_q <= 1'b0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            ack_q <= 1'b0;
            last_q <= 1'b0;
            lost_q <= 1'b0;
            gc_q <= 1'b0;
            ackbit_q <= 1'b1;
            busy_q <= 1'b0;
            pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            code_q <= code_d;
            tx_data_q <= tx_data_d;
            own_q <= own_d;
            timer_q <= timer_d;
            rdata_q <= rdata_d;
            int_q <= int_d;
            start_q <= start_d;
            stop_q <= stop_d;
            ack_q <= ack_d;
            last_q <= last_d;
            lost_q <= lost_d;
            gc_q <= gc_d;
            ackbit_q <= ackbit_d;
            busy_q <= busy_d;
            pend_q <= pend_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
        end
    end

    // open drain: the output value stays low, only the enable moves
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_oe_q;
    assign sda_oe_o = sda_oe_q;
    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_addr_done;
        state_q == S_ADDR_ACK && cnt_q == ACK_DONE && ev.scl_fall && !gc_q;
    endsequence
    sequence s_ack_slot;
        state_q == S_TX_ACK && ev.scl_fall;
    endsequence
    sequence s_tx_release;
        state_q == S_WAIT && !int_q && is_tx_code(code_q);
    endsequence

    property p_addr_read;
        @(posedge mclk_i) disable iff (reset_i)
        s_addr_done and !lost_q |=> int_q && code_q == ST_ADDR_RD_ACK && scl_oe_o;
    endproperty
    a_addr_read: assert property (p_addr_read) else $error("read address not reported"); // [R1]

    property p_arb_lost;
        @(posedge mclk_i) disable iff (reset_i)
        s_addr_done and lost_q |=> int_q && code_q == ST_ARB_LOST_RD ##1 state_q == S_WAIT;
    endproperty
    a_arb_lost: assert property (p_arb_lost) else $error("lost arbitration code wrong"); // [R4]

    property p_last;
        @(posedge mclk_i) disable iff (reset_i)
        s_tx_release and !ack_q |=> last_q && state_q == S_TX_BIT;
    endproperty
    a_last: assert property (p_last) else $error("final byte not marked"); // [R2]

    property p_more;
        @(posedge mclk_i) disable iff (reset_i)
        s_tx_release and ack_q |=> !last_q && !scl_oe_o;
    endproperty
    a_more: assert property (p_more) else $error("byte wrongly marked final"); // [R3]

    property p_data_ack;
        @(posedge mclk_i) disable iff (reset_i)
        s_ack_slot and !ackbit_q && !last_q |=> code_q == ST_DATA_ACK && int_q;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("acked byte not reported"); // [R5]

    property p_nack;
        @(posedge mclk_i) disable iff (reset_i)
        s_ack_slot and ackbit_q |=> code_q == ST_DATA_NACK && int_q && scl_oe_o;
    endproperty
    a_nack: assert property (p_nack) else $error("unacked byte not reported"); // [R7]

    property p_final;
        @(posedge mclk_i) disable iff (reset_i)
        s_ack_slot and !ackbit_q && last_q |=> code_q == ST_LAST_ACK;
    endproperty
    a_final: assert property (p_final) else $error("final ack not reported"); // [R19]

    property p_no_info;
        @(posedge mclk_i) disable iff (reset_i)
        reg_rd_i && reg_addr_i == OFS_STAT && !int_q |=> reg_rdata_o == ST_NO_INFO;
    endproperty
    a_no_info: assert property (p_no_info) else $error("idle status not shown"); // [R10]

    property p_bus_err;
        @(posedge mclk_i) disable iff (reset_i)
        bus_err_evt |=> int_q && code_q == ST_BUS_ERR && !sda_oe_o && !scl_oe_o;
    endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error not flagged"); // [R12]

    property p_uninvolved;
        @(posedge mclk_i) disable iff (reset_i)
        (ev.start_det || ev.stop_det) && !involved && state_q != S_ERR |=> state_q != S_ERR;
    endproperty
    a_uninvolved: assert property (p_uninvolved) else $error("error while not involved"); // [R18]

    property p_recover;
        @(posedge mclk_i) disable iff (reset_i)
        state_q == S_ERR && !int_q && stop_q && !ctrl_wr |=> state_q == S_IDLE && !stop_q;
    endproperty
    a_recover: assert property (p_recover) else $error("recovery failed"); // [R15]

    property p_err_quiet;
        @(posedge mclk_i) disable iff (reset_i)
        state_q == S_ERR |-> !sda_oe_o && !scl_oe_o;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("line driven in error state"); // [R16]

    property p_hold;
        @(posedge mclk_i) disable iff (reset_i)
        state_q == S_WAIT && int_q |-> scl_oe_o;
    endproperty
    a_hold: assert property (p_hold) else $error("clock not held"); // [R20]

    property p_start;
        @(posedge mclk_i) disable iff (reset_i)
        state_q == S_IDLE && pend_q && !busy_q |=> sda_oe_o && state_q == S_START;
    endproperty
    a_start: assert property (p_start) else $error("start not issued"); // [R9]
endmodule // i2c_target_tx
`default_nettype wire

// file: hw/i2c_tt_pkg.sv
// constants, codes and types shared by the target-transmit block
package i2c_tt_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int START_HOLD_NS = 4000;
    localparam logic [7:0] START_HOLD_CYC =
        8'((START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // register offsets on the plain register port
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_ADR = 4'hC;

    // control register field positions
    localparam int CTRL_START = 5;
    localparam int CTRL_STOP = 4;
    localparam int CTRL_INT = 3;
    localparam int CTRL_ACK = 2;

    // reset values
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_TX_DATA = 8'h00;

    // byte framing
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_DRIVE = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    // status codes
    localparam logic [7:0] ST_BUS_ERR = 8'h00;
    localparam logic [7:0] ST_START_SENT = 8'h08;
    localparam logic [7:0] ST_ADDR_RD_ACK = 8'hA8;
    localparam logic [7:0] ST_ARB_LOST_RD = 8'hB0;
    localparam logic [7:0] ST_DATA_ACK = 8'hB8;
    localparam logic [7:0] ST_DATA_NACK = 8'hC0;
    localparam logic [7:0] ST_LAST_ACK = 8'hC8;
    localparam logic [7:0] ST_NO_INFO = 8'hF8;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ADDR = 4'h1,
        S_ADDR_ACK = 4'h2,
        S_TX_BIT = 4'h3,
        S_TX_ACK = 4'h4,
        S_WAIT = 4'h5,
        S_ERR = 4'h6,
        S_START = 4'h7
    } state_t;

    // codes after which software hands over another byte to send
    function automatic logic is_tx_code(input logic [7:0] code);
        return (code == ST_ADDR_RD_ACK) || (code == ST_ARB_LOST_RD) || (code == ST_DATA_ACK);
    endfunction

endpackage

// file: hw/line_events_if.sv
// synchronised bus line levels and detected bus conditions
`timescale 1ns/1ps
`default_nettype none
interface line_events_if;
    logic scl_lvl;
    logic sda_lvl;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport src (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
    modport dst (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// file: hw/line_watch.sv
// bus line synchroniser and start/stop/edge detector
`timescale 1ns/1ps
`default_nettype none
module line_watch (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // detected events
    line_events_if.src ev
);
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic scl_m_d, scl_s_d, scl_p_d, sda_m_d, sda_s_d, sda_p_d;

    always_comb begin
        scl_m_d = scl_i;
        scl_s_d = scl_m_q;
        scl_p_d = scl_s_q;
        sda_m_d = sda_i;
        sda_s_d = sda_m_q;
        sda_p_d = sda_s_q;
    end

    // idle bus floats high, so reset to one
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= scl_m_d;
            scl_s_q <= scl_s_d;
            scl_p_q <= scl_p_d;
            sda_m_q <= sda_m_d;
            sda_s_q <= sda_s_d;
            sda_p_q <= sda_p_d;
        end
    end

    // only the second and third stages are looked at
    assign ev.scl_lvl = scl_s_q;
    assign ev.sda_lvl = sda_s_q;
    assign ev.scl_rise = scl_s_q & ~scl_p_q;
    assign ev.scl_fall = ~scl_s_q & scl_p_q;
    assign ev.start_det = scl_s_q & scl_p_q & ~sda_s_q & sda_p_q;
    assign ev.stop_det = scl_s_q & scl_p_q & sda_s_q & ~sda_p_q;
endmodule // line_watch
`default_nettype wire

// file: verification/i2c_remote_ctrl.sv
// remote bus controller model that reads bytes from the target
`timescale 1ns/1ps
`default_nettype none
module i2c_remote_ctrl (
    // wire levels
    input wire logic scl_i,
    input wire logic sda_i,
    // pulls, high drags the line low
    output logic scl_pull_o,
    output logic sda_pull_o
);
    // released lines float high through the pull-ups
    initial begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one link clock of 160 ns, target may stretch the low phase
    task automatic clk_pulse(output logic b);
        #80 scl_pull_o = 1'b0;
        wait (scl_i === 1'b1);
        #40 b = sda_i;
        #40 scl_pull_o = 1'b1;
    endtask
    task automatic put_bit(input logic b);
        logic x;
        sda_pull_o = !b;
        clk_pulse(x);
    endtask
    task automatic get_bit(output logic b);
        sda_pull_o = 1'b0;
        clk_pulse(b);
    endtask
    task automatic start_cond();
        sda_pull_o = 1'b1;
        #80 scl_pull_o = 1'b1;
    endtask
    // start in the middle of a data bit
    task automatic err_start();
        #80 scl_pull_o = 1'b0;
        wait (scl_i === 1'b1);
        #40 start_cond();
    endtask
    task automatic stop_cond();
        sda_pull_o = 1'b1;
        #80 scl_pull_o = 1'b0;
        wait (scl_i === 1'b1);
        #80 sda_pull_o = 1'b0;
        #80;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(ack);
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(ack);
    endtask
endmodule // i2c_remote_ctrl
`default_nettype wire

// file: verification/tb_i2c_target_tx.sv
// self-checking bench for the target-transmit block
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_target_tx;
    import i2c_tt_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic arb_lost = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_p = 1'b0;
    logic [7:0] rdata;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, scl_pull, sda_pull, scl_w, sda_w;
    int bad_count = 0;
    int num_checks = 0;
    logic [7:0] exp_q[$];
    always #10 mclk_i = ~mclk_i;
    assign scl_w = ~((scl_oe_o & ~scl_o) | scl_pull);
    assign sda_w = ~((sda_oe_o & ~sda_o) | sda_pull);
    i2c_target_tx u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .ctrl_arb_lost_i(arb_lost), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata));
    i2c_remote_ctrl u_far (.scl_i(scl_w), .sda_i(sda_w), .scl_pull_o(scl_pull),
        .sda_pull_o(sda_pull));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(v);
        @(posedge mclk_i);
        reg_rd <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge mclk_i) begin
        if (rd_p && exp_q.size() > 0) check(rdata, exp_q.pop_front());
        rd_p <= reg_rd;
    end
    // bounded wait, a hung line counts as a mismatch
    task automatic wait_oe(input logic on_scl);
        int n;
        n = 0;
        while (((on_scl ? scl_oe_o : sda_oe_o) !== 1'b1) && n < 400) begin
            @(posedge mclk_i);
            n++;
        end
        check({7'h00, (on_scl ? scl_oe_o : sda_oe_o)}, 8'h01);
    endtask
    task automatic serve(input logic [7:0] st, input logic [7:0] dat, input logic [7:0] ctl);
        wait_oe(1'b1);
        repeat (20) @(posedge mclk_i);
        check({7'h00, scl_oe_o}, 8'h01);
        reg_read(OFS_STAT, st);
        reg_write(OFS_DATA, dat);
        reg_write(OFS_CTRL, ctl);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        $display("ERROR %0t: watchdog expired", $time);
        conclude();
    end
    initial begin
        logic [7:0] own, b, d1, d2;
        logic a;
        void'($urandom(32'h08BEFE54));
        own = 8'($urandom_range(32'h7E, 32'h08));
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        reg_read(OFS_STAT, ST_NO_INFO);
        reg_read(4'h2, 8'h00);
        reg_write(OFS_ADR, {own[6:0], 1'b0});
        reg_write(OFS_CTRL, 8'h04);
        u_far.start_cond();
        u_far.send_byte({own[6:0], 1'b1}, a);
        check({7'h00, a}, 8'h00);
        serve(ST_ADDR_RD_ACK, d1, 8'h04);
        u_far.get_byte(1'b0, b);
        check(b, d1);
        serve(ST_DATA_ACK, d2, 8'h00);
        u_far.get_byte(1'b0, b);
        check(b, d2);
        serve(ST_LAST_ACK, d2, 8'h00);
        u_far.stop_cond();
        reg_read(OFS_STAT, ST_NO_INFO);
        $display("test 1 done");
        // acknowledge flag left low: own address ignored
        u_far.start_cond();
        u_far.send_byte({own[6:0], 1'b1}, a);
        check({7'h00, a}, 8'h01);
        u_far.stop_cond();
        reg_read(OFS_STAT, ST_NO_INFO);
        $display("test 2 done");
        reg_write(OFS_CTRL, 8'h04);
        u_far.start_cond();
        fork
            u_far.send_byte({own[6:0], 1'b1}, a);
            begin
                repeat (30) @(posedge mclk_i);
                arb_lost <= 1'b1;
                @(posedge mclk_i);
                arb_lost <= 1'b0;
            end
        join
        serve(ST_ARB_LOST_RD, d1, 8'h04);
        u_far.get_byte(1'b1, b);
        check(b, d1);
        serve(ST_DATA_NACK, d1, 8'h24);
        u_far.stop_cond();
        wait_oe(1'b0);
        wait_oe(1'b1);
        reg_read(OFS_STAT, ST_START_SENT);
        reg_write(OFS_CTRL, 8'h04);
        repeat (3) @(posedge mclk_i);
        check({6'h00, scl_oe_o, sda_oe_o}, 8'h00);
        $display("test 3 done");
        u_far.start_cond();
        u_far.send_byte({own[6:0], 1'b1}, a);
        check({7'h00, a}, 8'h00);
        serve(ST_ADDR_RD_ACK, 8'hFF, 8'h04);
        repeat (3) u_far.get_bit(a);
        u_far.err_start();
        repeat (10) @(posedge mclk_i);
        check({4'h0, scl_o, sda_o, scl_oe_o, sda_oe_o}, 8'h00);
        reg_read(OFS_STAT, ST_BUS_ERR);
        reg_write(OFS_CTRL, 8'h14);
        reg_read(OFS_CTRL, 8'h04);
        reg_read(OFS_STAT, ST_NO_INFO);
        u_far.stop_cond();
        u_far.start_cond();
        u_far.stop_cond();
        reg_read(OFS_STAT, ST_NO_INFO);
        $display("test 4 done");
        repeat (5) @(posedge mclk_i);
        conclude();
    end
endmodule // tb_i2c_target_tx
`default_nettype wire
